/* tcc_core.sv */
// counting core with compare, terminal count and two capture registers
// assumes the top holds run state and turns capture sources into pulses
`timescale 1ns/1ps
`default_nettype none
module tcc_core
  import tcc_pkg::*;
#(
  parameter int WIDTH = CNT_W
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic run,
  input wire logic counter_clear,
  input wire logic clear_after,
  input wire logic rise_event,
  input wire logic fall_event,
  input wire logic [WIDTH-1:0] period,
  input wire logic [WIDTH-1:0] compare,
  output logic [WIDTH-1:0] count,
  output logic [WIDTH-1:0] rise_capture,
  output logic [WIDTH-1:0] fall_capture,
  output logic terminal_pulse,
  output logic compare_pulse
);
  logic any_capture;
  assign any_capture = rise_event | fall_event;
  // counter: software clear, clear after capture, wrap at period
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      count <= '0;
    end else if (counter_clear) begin
      count <= '0;
    end else if (any_capture && clear_after) begin
      count <= '0;
    end else if (run) begin
      count <= (count == period) ? '0 : count + 1'b1;
    end
  end
  // capture registers; sources may coincide
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rise_capture <= '0;
      fall_capture <= '0;
    end else if (counter_clear) begin
      rise_capture <= '0;
      fall_capture <= '0;
    end else begin
      if (rise_event) begin
        rise_capture <= count;
      end
      if (fall_event) begin
        fall_capture <= count;
      end
    end
  end
  // event pulses while counting
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      terminal_pulse <= 1'b0;
      compare_pulse <= 1'b0;
    end else begin
      terminal_pulse <= run && !counter_clear && count == period;
      compare_pulse <= run && !counter_clear && count == compare;
    end
  end
endmodule : tcc_core
`default_nettype wire

/* tcc_edge.sv */
// edge detector for a synchronous pin level
// assumes the pin is already synchronous to aclk
`timescale 1ns/1ps
`default_nettype none
module tcc_edge (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic level,
  output logic rise,
  output logic fall
);
  logic last;
  // previous level
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      last <= 1'b0;
    end else begin
      last <= level;
    end
  end
  // one-cycle edge pulses
  assign rise = level & ~last;
  assign fall = ~level & last;
endmodule : tcc_edge
`default_nettype wire

/* tcc_pin_model.sv */
// model of the encoder and external capture pins
// assumes the bench names the wanted levels; pins move at the next edge
`timescale 1ns/1ps
`default_nettype none
module tcc_pin_model (
  input wire logic aclk,
  input wire logic [3:0] want,
  output logic index_pin,
  output logic phase_a,
  output logic phase_b,
  output logic ext_pin
);
  // quiet levels before the first edge
  initial {index_pin, phase_a, phase_b, ext_pin} = 4'h0;
  // pins follow the wanted levels one edge later, like a synchronised source
  always @(posedge aclk) begin
    {index_pin, phase_a, phase_b, ext_pin} <= want;
  end
endmodule : tcc_pin_model
`default_nettype wire

/* tcc_pkg.sv */
// package for the timer capture status and configuration block
// assumes a 32-bit axi4-lite bus; register index times four is the byte address
package tcc_pkg;
  localparam int ADDR_W = 20;
  localparam int CNT_W = 16;
  // register indices
  localparam logic [15:0] RUN_INDEX = 16'hA050;
  localparam logic [15:0] CTRL_STATUS_INDEX = 16'hA051;
  localparam logic [15:0] CONFIG_THREE_INDEX = 16'hA052;
  localparam logic [15:0] PERIOD_INDEX = 16'hA054;
  localparam logic [15:0] COMPARE_INDEX = 16'hA056;
  localparam logic [15:0] COUNT_INDEX = 16'hA058;
  localparam logic [15:0] RISE_CAPTURE_INDEX = 16'hA060;
  localparam logic [15:0] FALL_CAPTURE_INDEX = 16'hA062;
  localparam logic [15:0] IRQ_STATUS_INDEX = 16'hA070;
  localparam logic [15:0] IRQ_MASK_INDEX = 16'hA071;
  // control and status field positions
  localparam int COUNTER_RESET_BIT = 7;
  localparam int INDEX_LEVEL_BIT = 6;
  localparam int PHASE_A_LEVEL_BIT = 5;
  localparam int PHASE_B_LEVEL_BIT = 4;
  localparam int TERMINAL_POL_BIT = 3;
  localparam int COMPARE_POL_BIT = 2;
  localparam int TERMINAL_FLAG_BIT = 1;
  localparam int COMPARE_FLAG_BIT = 0;
  // configuration three field positions
  localparam int TERMINAL_IEN_BIT = 7;
  localparam int COMPARE_IEN_BIT = 6;
  localparam int QUAD_CAPTURE_BIT = 5;
  localparam int CLEAR_AFTER_BIT = 4;
  localparam int EXT_RISE_BIT = 3;
  localparam int EXT_FALL_BIT = 2;
  localparam int SW_RISE_BIT = 1;
  localparam int SW_FALL_BIT = 0;
  // interrupt status field positions
  localparam int IRQ_TERMINAL_BIT = 0;
  localparam int IRQ_COMPARE_BIT = 1;
  localparam int IRQ_CAPTURE_BIT = 2;
  // reset values
  localparam logic [7:0] CONFIG_THREE_RESET = 8'h00;
  localparam logic [15:0] PERIOD_RESET = 16'hFFFF;
  localparam logic [15:0] COMPARE_RESET = 16'h0000;
  localparam logic [2:0] IRQ_MASK_RESET = 3'h0;
  // axi responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : tcc_pkg

/* tcc_top.sv */
// timer capture status and configuration with an axi4-lite register slave
// assumes pins are synchronous to aclk; one write and one read at a time
//
// Overview of operation
// - counter reset write clears counter and captures
// - counter stays stopped after that reset
// - terminal count sets terminal flag
// - terminal flag holds until written zero
// - compare match sets compare flag
// - compare flag holds until written zero
// - index status reads live pin level
// - phase a status reads live pin
// - phase b status reads live pin
// - polarity bit inverts terminal output
// - polarity bit inverts compare output
// - config three resets zero, strobes write-only
// - clear-after-capture zeroes counter on capture
// - rising external edge is capture event
// - falling external edge is capture event
// - software strobes capture count and self-clear
//
// The implementer's own choice: the AXI4-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
module tcc_top
  import tcc_pkg::*;
#(
  parameter int WIDTH = CNT_W
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic index_pin,
  input wire logic quad_phase_a_input,
  input wire logic quad_phase_b_input,
  input wire logic ext_capture_pin,
  output logic terminal_out,
  output logic compare_out,
  output logic irq
);

  ////////////////////////////////////////////////////////////////////////////
  // declarations

  logic [ADDR_W-1:0] aw_addr;
  logic aw_held;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic w_held;
  logic do_write;
  logic [15:0] w_index;
  logic [15:0] r_index;
  logic run;
  logic terminal_output_polarity;
  logic compare_output_polarity;
  logic terminal_count_flag;
  logic compare_match_flag;
  logic [7:2] config_three;
  logic counter_reset_strobe;
  logic sw_capture_rise_strobe;
  logic sw_capture_fall_strobe;
  logic [WIDTH-1:0] period;
  logic [WIDTH-1:0] compare;
  logic [WIDTH-1:0] timer_count_value;
  logic [WIDTH-1:0] rise_capture_value;
  logic [WIDTH-1:0] fall_capture_value;
  logic terminal_pulse;
  logic compare_pulse;
  logic ext_rise;
  logic ext_fall;
  logic index_rise;
  logic rise_event;
  logic fall_event;
  logic [2:0] irq_status;
  logic [2:0] irq_mask;
  logic [2:0] irq_events;
  logic [31:0] next_rdata;
  logic next_rvalid_err;

  // byte address to register index; low two bits ignored
  function automatic logic [15:0] to_index(input logic [ADDR_W-1:0] addr);
    to_index = 16'(addr >> 2);
  endfunction : to_index

  // byte lane enable: true when the write strobe of the given lane is set
  function automatic logic lane_on(input logic [3:0] strb, input int lane);
    lane_on = strb[lane];
  endfunction : lane_on

  ////////////////////////////////////////////////////////////////////////////
  // axi write channel: address and data taken in either order

  assign w_index = to_index(aw_addr);
  assign do_write = aw_held && w_held && !s_axi_bvalid;

  // hold write address until the response
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      aw_addr <= '0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_held <= 1'b1;
      aw_addr <= s_axi_awaddr;
    end else if (do_write) begin
      aw_held <= 1'b0;
    end
  end

  // hold write data until the response
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held <= 1'b0;
      w_data <= '0;
      w_strb <= '0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_held <= 1'b1;
      w_data <= s_axi_wdata;
      w_strb <= s_axi_wstrb;
    end else if (do_write) begin
      w_held <= 1'b0;
    end
  end

  // ready flops: accept again only after the held beat is consumed
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
    end else begin
      s_axi_awready <= !aw_held && !(s_axi_awvalid && s_axi_awready) && !s_axi_bvalid;
      s_axi_wready <= !w_held && !(s_axi_wvalid && s_axi_wready) && !s_axi_bvalid;
    end
  end

  // write response; unmapped index answers slverr
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else if (do_write) begin
      s_axi_bvalid <= 1'b1;
      unique case (w_index)
        RUN_INDEX, CTRL_STATUS_INDEX, CONFIG_THREE_INDEX, PERIOD_INDEX, COMPARE_INDEX,
        COUNT_INDEX, RISE_CAPTURE_INDEX, FALL_CAPTURE_INDEX, IRQ_STATUS_INDEX,
        IRQ_MASK_INDEX: s_axi_bresp <= RESP_OKAY;
        default: s_axi_bresp <= RESP_SLVERR;
      endcase
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // control register effects

  // run bit: cleared by counter reset, set only by software
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      run <= 1'b0;
    end else if (counter_reset_strobe) begin
      run <= 1'b0;
    end else if (do_write && w_index == RUN_INDEX && lane_on(w_strb, 0)) begin
      run <= w_data[0];
    end
  end

  // one-cycle strobes, write-only, read back as zero
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      counter_reset_strobe <= 1'b0;
      sw_capture_rise_strobe <= 1'b0;
      sw_capture_fall_strobe <= 1'b0;
    end else begin
      counter_reset_strobe <= do_write && w_index == CTRL_STATUS_INDEX && lane_on(w_strb, 0)
                              && w_data[COUNTER_RESET_BIT];
      sw_capture_rise_strobe <= do_write && w_index == CONFIG_THREE_INDEX
                                && lane_on(w_strb, 0) && w_data[SW_RISE_BIT];
      sw_capture_fall_strobe <= do_write && w_index == CONFIG_THREE_INDEX
                                && lane_on(w_strb, 0) && w_data[SW_FALL_BIT];
    end
  end

  // output polarity bits
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      terminal_output_polarity <= 1'b0;
      compare_output_polarity <= 1'b0;
    end else if (do_write && w_index == CTRL_STATUS_INDEX && lane_on(w_strb, 0)) begin
      terminal_output_polarity <= w_data[TERMINAL_POL_BIT];
      compare_output_polarity <= w_data[COMPARE_POL_BIT];
    end
  end

  // flags: hardware set wins; only a written zero clears
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      terminal_count_flag <= 1'b0;
      compare_match_flag <= 1'b0;
    end else begin
      terminal_count_flag <= terminal_pulse | (terminal_count_flag & ~(do_write
        && w_index == CTRL_STATUS_INDEX && lane_on(w_strb, 0)
        && !w_data[TERMINAL_FLAG_BIT]));
      compare_match_flag <= compare_pulse | (compare_match_flag & ~(do_write
        && w_index == CTRL_STATUS_INDEX && lane_on(w_strb, 0)
        && !w_data[COMPARE_FLAG_BIT]));
    end
  end

  // configuration three, read-write upper six bits
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      config_three <= CONFIG_THREE_RESET[7:2];
    end else if (do_write && w_index == CONFIG_THREE_INDEX && lane_on(w_strb, 0)) begin
      config_three <= w_data[7:2];
    end
  end

  // period and compare values, 16 bits in the low two lanes
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      period <= PERIOD_RESET;
      compare <= COMPARE_RESET;
    end else if (do_write) begin
      for (int i = 0; i < 2; i++) begin
        if (lane_on(w_strb, i) && w_index == PERIOD_INDEX) begin
          period[i*8 +: 8] <= w_data[i*8 +: 8];
        end
        if (lane_on(w_strb, i) && w_index == COMPARE_INDEX) begin
          compare[i*8 +: 8] <= w_data[i*8 +: 8];
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // capture sources and counting core

  tcc_edge u_ext_edge (
    .aclk(aclk),
    .aresetn(aresetn),
    .level(ext_capture_pin),
    .rise(ext_rise),
    .fall(ext_fall)
  );

  tcc_edge u_index_edge (
    .aclk(aclk),
    .aresetn(aresetn),
    .level(index_pin),
    .rise(index_rise),
    .fall()
  );

  // all capture sources may coexist
  assign rise_event = (config_three[EXT_RISE_BIT] & ext_rise)
                    | (config_three[QUAD_CAPTURE_BIT] & index_rise)
                    | sw_capture_rise_strobe;
  assign fall_event = (config_three[EXT_FALL_BIT] & ext_fall)
                    | sw_capture_fall_strobe;

  tcc_core #(
    .WIDTH(WIDTH)
  ) u_core (
    .aclk(aclk),
    .aresetn(aresetn),
    .run(run),
    .counter_clear(counter_reset_strobe),
    .clear_after(config_three[CLEAR_AFTER_BIT]),
    .rise_event(rise_event),
    .fall_event(fall_event),
    .period(period),
    .compare(compare),
    .count(timer_count_value),
    .rise_capture(rise_capture_value),
    .fall_capture(fall_capture_value),
    .terminal_pulse(terminal_pulse),
    .compare_pulse(compare_pulse)
  );

  ////////////////////////////////////////////////////////////////////////////
  // outputs and interrupts

  // polarity-selected event outputs
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      terminal_out <= 1'b0;
      compare_out <= 1'b0;
    end else begin
      terminal_out <= terminal_pulse ^ terminal_output_polarity;
      compare_out <= compare_pulse ^ compare_output_polarity;
    end
  end

  assign irq_events = {rise_event | fall_event, compare_pulse, terminal_pulse};

  // sticky status, write one to clear, set wins
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_status <= '0;
    end else if (do_write && w_index == IRQ_STATUS_INDEX && lane_on(w_strb, 0)) begin
      irq_status <= irq_events | (irq_status & ~w_data[2:0]);
    end else begin
      irq_status <= irq_events | irq_status;
    end
  end

  // interrupt mask
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_mask <= IRQ_MASK_RESET;
    end else if (do_write && w_index == IRQ_MASK_INDEX && lane_on(w_strb, 0)) begin
      irq_mask <= w_data[2:0];
    end
  end

  // level interrupt
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq <= 1'b0;
    end else begin
      irq <= (terminal_count_flag & config_three[TERMINAL_IEN_BIT])
           | (compare_match_flag & config_three[COMPARE_IEN_BIT])
           | |(irq_status & irq_mask);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // axi read channel

  assign r_index = to_index(s_axi_araddr);

  // read mux; pin levels taken live at the read
  always_comb begin
    next_rdata = '0;
    next_rvalid_err = 1'b0;
    unique case (r_index)
      RUN_INDEX: next_rdata[0] = run;
      CTRL_STATUS_INDEX: begin
        next_rdata[INDEX_LEVEL_BIT] = index_pin;
        next_rdata[PHASE_A_LEVEL_BIT] = quad_phase_a_input;
        next_rdata[PHASE_B_LEVEL_BIT] = quad_phase_b_input;
        next_rdata[TERMINAL_POL_BIT] = terminal_output_polarity;
        next_rdata[COMPARE_POL_BIT] = compare_output_polarity;
        next_rdata[TERMINAL_FLAG_BIT] = terminal_count_flag;
        next_rdata[COMPARE_FLAG_BIT] = compare_match_flag;
      end
      CONFIG_THREE_INDEX: next_rdata[7:2] = config_three;
      PERIOD_INDEX: next_rdata[WIDTH-1:0] = period;
      COMPARE_INDEX: next_rdata[WIDTH-1:0] = compare;
      COUNT_INDEX: next_rdata[WIDTH-1:0] = timer_count_value;
      RISE_CAPTURE_INDEX: next_rdata[WIDTH-1:0] = rise_capture_value;
      FALL_CAPTURE_INDEX: next_rdata[WIDTH-1:0] = fall_capture_value;
      IRQ_STATUS_INDEX: next_rdata[2:0] = irq_status;
      IRQ_MASK_INDEX: next_rdata[2:0] = irq_mask;
      default: next_rvalid_err = 1'b1;
    endcase
  end

  // read address ready while no answer is pending
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
    end else begin
      s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
    end
  end

  // read data one cycle after the address is taken
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= next_rdata;
      s_axi_rresp <= next_rvalid_err ? RESP_SLVERR : RESP_OKAY;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule : tcc_top
`default_nettype wire

/* tcc_top_sva.sv */
// checker for the register slave handshakes and status reads
// assumes a bind to tcc_top; everything lives in the aclk domain
`timescale 1ns/1ps
`default_nettype none
module tcc_top_sva
  import tcc_pkg::*;
#(
  parameter int WIDTH = CNT_W
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic index_pin,
  input wire logic quad_phase_a_input,
  input wire logic quad_phase_b_input
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  ////////////////////////////////////////////////////////////
  // read handshakes on the status and configuration registers
  logic ar_hs;
  logic st_rd;
  logic cf_rd;
  assign ar_hs = s_axi_arvalid && s_axi_arready;
  assign st_rd = ar_hs && (s_axi_araddr == {2'h0, CTRL_STATUS_INDEX, 2'h0});
  assign cf_rd = ar_hs && (s_axi_araddr == {2'h0, CONFIG_THREE_INDEX, 2'h0});
  ////////////////////////////////////////////////////////////
  property p_write_answer;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##[1:2] s_axi_bvalid;
  endproperty
  a_write_answer: assert property (p_write_answer) else $error("write answer late");
  property p_one_write;
    s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
  endproperty
  a_one_write: assert property (p_one_write) else $error("write taken during response");
  property p_bresp_done;
    s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid ##[0:2] s_axi_awready;
  endproperty
  a_bresp_done: assert property (p_bresp_done) else $error("write response not closed");
  property p_read_answer;
    ar_hs |=> s_axi_rvalid;
  endproperty
  a_read_answer: assert property (p_read_answer) else $error("read answer late");
  property p_rresp_done;
    s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid;
  endproperty
  a_rresp_done: assert property (p_rresp_done) else $error("read response repeated");
  property p_index_live;
    st_rd |=> s_axi_rdata[INDEX_LEVEL_BIT] == $past(index_pin);
  endproperty
  a_index_live: assert property (p_index_live) else $error("index level wrong");
  property p_phase_a_live;
    st_rd |=> s_axi_rdata[PHASE_A_LEVEL_BIT] == $past(quad_phase_a_input);
  endproperty
  a_phase_a_live: assert property (p_phase_a_live) else $error("phase a wrong");
  property p_phase_b_live;
    st_rd |=> s_axi_rdata[PHASE_B_LEVEL_BIT] == $past(quad_phase_b_input);
  endproperty
  a_phase_b_live: assert property (p_phase_b_live) else $error("phase b wrong");
  property p_strobes_read_zero;
    cf_rd |=> s_axi_rdata[1:0] == 2'h0 && s_axi_rdata[31:8] == 24'h0;
  endproperty
  a_strobes_read_zero: assert property (p_strobes_read_zero) else $error("strobe read");
endmodule : tcc_top_sva
`default_nettype wire

/* timer_capture_status_config_bench.sv */
// self-checking bench for the timer capture status and configuration block
// assumes tcc_top, tcc_pin_model and tcc_top_sva are compiled first
`timescale 1ns/1ps
`default_nettype none
module timer_capture_status_config_bench
  import tcc_pkg::*;
;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [ADDR_W-1:0] s_axi_awaddr = '0;
  logic [ADDR_W-1:0] s_axi_araddr = '0;
  logic [31:0] s_axi_wdata = '0;
  logic s_axi_awvalid = 1'b0;
  logic s_axi_wvalid = 1'b0;
  logic s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0;
  logic s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, rs;
  logic [31:0] s_axi_rdata, rv, c1, c2;
  logic index_pin, phase_a, phase_b, ext_pin, terminal_out, compare_out, irq;
  logic [3:0] pin_want = 4'h0;
  int err_total = 0;
  int n_compared = 0;
  int cyc = 0;
  int np, nc;
  // 40 MHz clock
  always #12.5 aclk = ~aclk;
  tcc_top dut_u (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awprot(3'h0), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arprot(3'h0),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .index_pin(index_pin), .quad_phase_a_input(phase_a), .quad_phase_b_input(phase_b),
    .ext_capture_pin(ext_pin), .terminal_out(terminal_out), .compare_out(compare_out),
    .irq(irq));
  tcc_pin_model pins_u (.aclk(aclk), .want(pin_want), .index_pin(index_pin),
    .phase_a(phase_a), .phase_b(phase_b), .ext_pin(ext_pin));
  ////////////////////////////////////////////////////////////
  // comparison, bus cycles and closing report
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
    n_compared++;
    if (seen !== exp) begin
      err_total++;
      $display("wrong value at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask : chk
  task automatic tick(input int n);
    repeat (n) @(posedge aclk);
  endtask : tick
  task automatic wr(input logic [15:0] idx, input logic [31:0] d);
    @(posedge aclk);
    s_axi_awaddr <= {2'h0, idx, 2'h0};
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    rs = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask : wr
  task automatic rd(input logic [15:0] idx);
    @(posedge aclk);
    s_axi_araddr <= {2'h0, idx, 2'h0};
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    rv = s_axi_rdata;
    rs = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask : rd
  task automatic rdchk(input logic [15:0] idx, input logic [31:0] exp, input string what);
    rd(idx);
    chk(rv, exp, what);
  endtask : rdchk
  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : wrap_up
  // hang guard
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      wrap_up();
    end
  end
  ////////////////////////////////////////////////////////////
  // test sequence
  initial begin
    tick(8);
    aresetn <= 1'b1;
    tick(1);
    rdchk(CONFIG_THREE_INDEX, 32'h0, "config three reset");
    chk({30'h0, terminal_out, compare_out}, 32'h0, "idle outputs");
    for (int i = 0; i < 8; i++) begin
      pin_want <= {i[2:0], 1'b0};
      tick(3);
      rdchk(CTRL_STATUS_INDEX, {25'h0, i[2:0], 4'h0}, "pin levels");
    end
    pin_want <= 4'h0;
    wr(CONFIG_THREE_INDEX, 32'hFF);
    rdchk(CONFIG_THREE_INDEX, 32'hFC, "config three bits");
    wr(CONFIG_THREE_INDEX, 32'h0);
    $display("test reset and status done");
    wr(PERIOD_INDEX, 32'h5);
    wr(COMPARE_INDEX, 32'h3);
    wr(RUN_INDEX, 32'h1);
    np = 0;
    nc = 0;
    repeat (30) begin
      @(posedge aclk);
      np += int'(terminal_out);
      nc += int'(compare_out);
    end
    wr(RUN_INDEX, 32'h0);
    chk(32'(np >= 4 && nc >= 4), 32'h1, "output pulses");
    chk({31'h0, irq}, 32'h0, "irq with enables off");
    rdchk(CTRL_STATUS_INDEX, 32'h3, "flags set");
    wr(CTRL_STATUS_INDEX, 32'h3);
    rdchk(CTRL_STATUS_INDEX, 32'h3, "flags after writing ones");
    wr(CONFIG_THREE_INDEX, 32'hC0);
    tick(3);
    chk({31'h0, irq}, 32'h1, "irq enabled");
    wr(CTRL_STATUS_INDEX, 32'hC);
    rdchk(CTRL_STATUS_INDEX, 32'hC, "flags cleared");
    tick(3);
    chk({31'h0, irq}, 32'h0, "irq after clear");
    chk({30'h0, terminal_out, compare_out}, 32'h3, "inverted idle");
    wr(CTRL_STATUS_INDEX, 32'h0);
    wr(CONFIG_THREE_INDEX, 32'h0);
    $display("test flags and irq done");
    wr(PERIOD_INDEX, 32'hFFFF);
    wr(RUN_INDEX, 32'h1);
    tick(20);
    wr(RUN_INDEX, 32'h0);
    rd(COUNT_INDEX);
    c1 = rv;
    wr(CONFIG_THREE_INDEX, 32'h3);
    tick(3);
    rdchk(RISE_CAPTURE_INDEX, c1, "sw rise capture");
    rdchk(FALL_CAPTURE_INDEX, c1, "sw fall capture");
    rdchk(CONFIG_THREE_INDEX, 32'h0, "strobes self-clear");
    rdchk(COUNT_INDEX, c1, "count kept");
    wr(RUN_INDEX, 32'h1);
    wr(CTRL_STATUS_INDEX, 32'h80);
    tick(20);
    rdchk(COUNT_INDEX, 32'h0, "count after reset");
    rdchk(RISE_CAPTURE_INDEX, 32'h0, "rise after reset");
    rdchk(FALL_CAPTURE_INDEX, 32'h0, "fall after reset");
    rdchk(RUN_INDEX, 32'h0, "run stopped");
    wr(RUN_INDEX, 32'h1);
    tick(20);
    wr(RUN_INDEX, 32'h0);
    rd(COUNT_INDEX);
    c2 = rv;
    wr(CONFIG_THREE_INDEX, 32'h0C);
    pin_want <= 4'h1;
    tick(4);
    rdchk(RISE_CAPTURE_INDEX, c2, "ext rise capture");
    rdchk(FALL_CAPTURE_INDEX, 32'h0, "no fall yet");
    pin_want <= 4'h0;
    tick(4);
    rdchk(FALL_CAPTURE_INDEX, c2, "ext fall capture");
    wr(CONFIG_THREE_INDEX, 32'h12);
    tick(3);
    rdchk(COUNT_INDEX, 32'h0, "clear after capture");
    wr(CONFIG_THREE_INDEX, 32'h20);
    pin_want <= 4'h8;
    tick(4);
    rdchk(RISE_CAPTURE_INDEX, 32'h0, "index capture");
    $display("test captures done");
    wr(16'hA040, 32'h1);
    chk({30'h0, rs}, {30'h0, RESP_SLVERR}, "unmapped write");
    rd(16'hA040);
    chk({30'h0, rs}, {30'h0, RESP_SLVERR}, "unmapped read");
    $display("test unmapped done");
    wrap_up();
  end
endmodule : timer_capture_status_config_bench
bind tcc_top tcc_top_sva #(.WIDTH(WIDTH)) chk_u (.aclk(aclk), .aresetn(aresetn),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .index_pin(index_pin),
  .quad_phase_a_input(quad_phase_a_input), .quad_phase_b_input(quad_phase_b_input));
`default_nettype wire
